// >>> logic/pcsia_core.sv
/*
 * Program counter, 8-level circular return stack and indirect address former.
 * Assumes the decoder presents one command per enabled cycle on clk_sys and that
 * pc_low writes, pointer writes and indirect accesses arrive as one-cycle strobes.
 * Limitations: the stack pointer is hidden and wraps with no status flag,
 * so deep call chains silently lose the oldest return address.
 * Indirect reads use the address registered in the previous cycle, so the
 * pointer must be stable for one cycle before an indirect read.
 */
// Function
// - Counter is 13 bits, low byte read/write
// - Upper bits not directly writable, loaded via latch
// - Any reset clears whole counter
// - Low byte write loads upper from latch
// - Call/goto top bits from latch 4:3
// - Eight 13-bit hidden return entries
// - Push counter plus one on call or vector
// - Pop counter on any return
// - Push/pop leave latch untouched
// - Stack wraps, overwriting oldest entry
// - No overflow or underflow status
// - Indirect port accesses pointed location
// - Self-pointed indirect read gives zero
// - Self-pointed indirect write stores nothing
// - Effective address is nine bits
`default_nettype none
module pcsia_core
	import pcsia_pkg::*;
#(
	parameter logic [12:0] VECTOR_ADDR = 13'h0004 // Interrupt vector address
) (
	input wire logic clk_sys, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic clk_en, // Freezes all state except the reset synchroniser when low
	input wire logic [5:0] flow_cmd, // One-hot flow command
	input wire logic [10:0] imm_addr, // Immediate jump address
	input wire logic latch_wr, // Write strobe to pc_high_latch
	input wire logic [7:0] latch_wdata, // Data for pc_high_latch
	input wire logic pcl_wr, // Write strobe to pc_low_byte_reg
	input wire logic [7:0] pcl_wdata, // Data for pc_low_byte_reg
	input wire logic fsr_wr, // Write strobe to file_pointer_reg
	input wire logic [7:0] fsr_wdata, // Data for file_pointer_reg
	input wire logic bank_select_bit, // Bank bit from status register
	input wire logic ind_rd, // Indirect read strobe
	input wire logic ind_wr, // Indirect write strobe
	input wire logic [7:0] ind_wdata, // Indirect write data
	input wire logic [7:0] mem_rdata, // Data memory read data
	output logic [12:0] pc, // Program counter to program memory
	output logic [7:0] pc_low_byte_reg, // Readable low byte
	output logic [7:0] file_pointer_reg, // Readable pointer
	output logic [8:0] mem_addr, // Effective indirect address
	output logic mem_wr, // Data memory write strobe
	output logic [7:0] mem_wdata, // Data memory write data
	output logic [7:0] ind_rdata // Indirect read result
);
	// Elaboration checks: the pointer and field widths below are fixed
	if (PCSIA_STK_DEPTH != 8) begin : g_bad_depth
		$error("Stack depth must be eight");
	end
	if (PCSIA_PC_W != 13) begin : g_bad_width
		$error("Counter width must be thirteen");
	end
	if (PCSIA_ADDR_W != 9) begin : g_bad_addr
		$error("Indirect address must be nine bits");
	end
	if (PCSIA_JMP_ADDR_W != 11) begin : g_bad_jump
		$error("Jump field must be eleven bits");
	end
	if (VECTOR_ADDR >= 13'h1fff) begin : g_bad_vector
		$error("VECTOR_ADDR out of range");
	end

	logic rst_meta;
	logic rst_sync_b;
	logic [4:0] pc_high_latch;
	logic [12:0] stack_mem [PCSIA_STK_DEPTH];
	logic [2:0] stk_ptr;
	logic [12:0] next_pc;
	logic [8:0] eff_addr;
	logic self_point;
	pcsia_cmd_t cmd;
	logic push_en; // Push this enabled cycle
	logic pop_en; // Pop this enabled cycle

	// Return address of the current counter value
	function automatic logic [12:0] pcsia_next_addr(input logic [12:0] cur);
		return cur + 13'h0001;
	endfunction : pcsia_next_addr

	// Commands that push a return address
	function automatic logic pcsia_is_push(input pcsia_cmd_t c);
		return (c == PCSIA_CMD_CALL) || (c == PCSIA_CMD_VECT);
	endfunction : pcsia_is_push

	// Commands that pop a return address
	function automatic logic pcsia_is_pop(input pcsia_cmd_t c);
		return c == PCSIA_CMD_RET;
	endfunction : pcsia_is_pop

	assign cmd = pcsia_cmd_t'(flow_cmd);

	// A low-byte write overrides the command, so the stack must not move
	assign push_en = clk_en && !pcl_wr && pcsia_is_push(cmd);
	assign pop_en = clk_en && !pcl_wr && pcsia_is_pop(cmd);

	// Reset release synchroniser
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// Effective address and self-pointing check
	assign eff_addr = {bank_select_bit, file_pointer_reg};
	assign self_point = (file_pointer_reg == PCSIA_INDIRECT_ACCESS_PORT_ADDR);

	// Next counter value
	always_comb begin
		next_pc = pc;
		case (cmd)
			PCSIA_CMD_INC: begin
				next_pc = pcsia_next_addr(pc);
			end
			PCSIA_CMD_JUMP, PCSIA_CMD_CALL: begin
				next_pc = {pc_high_latch[4:PCSIA_JMP_LATCH_LSB], imm_addr};
			end
			PCSIA_CMD_RET: begin
				next_pc = stack_mem[stk_ptr - 3'h1];
			end
			PCSIA_CMD_VECT: begin
				next_pc = VECTOR_ADDR;
			end
			default: begin
				next_pc = pc;
			end
		endcase
		// Low-byte write wins over any flow command
		if (pcl_wr) begin
			next_pc = {pc_high_latch, pcl_wdata};
		end
	end

	// Program counter
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pc <= PCSIA_PC_RST;
		end else if (clk_en) begin
			pc <= next_pc;
		end
	end

	// Low byte is a direct view of the counter flops
	assign pc_low_byte_reg = pc[7:0];

	// High latch, written only by software
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pc_high_latch <= PCSIA_LATCH_RST;
		end else if (clk_en && latch_wr) begin
			pc_high_latch <= latch_wdata[4:0];
		end
	end

	// Stack pointer wraps silently
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			stk_ptr <= 3'h0;
		end else if (push_en) begin
			stk_ptr <= stk_ptr + 3'h1;
		end else if (pop_en) begin
			stk_ptr <= stk_ptr - 3'h1;
		end
	end

	// Stack storage, pushes return address
	always_ff @(posedge clk_sys) begin
		if (push_en) begin
			stack_mem[stk_ptr] <= pcsia_next_addr(pc);
		end
	end

	// File pointer
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			file_pointer_reg <= PCSIA_FSR_RST;
		end else if (clk_en && fsr_wr) begin
			file_pointer_reg <= fsr_wdata;
		end
	end

	// Indirect access outputs
	// Writes aimed at the port itself are dropped here
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mem_addr <= 9'h000;
			mem_wr <= 1'b0;
			mem_wdata <= PCSIA_ZERO_BYTE;
		end else if (clk_en) begin
			mem_addr <= eff_addr;
			mem_wr <= ind_wr && !self_point;
			mem_wdata <= ind_wdata;
		end
	end

	// Indirect read result
	// Self-pointed reads return zero instead of memory data
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ind_rdata <= PCSIA_ZERO_BYTE;
		end else if (clk_en && ind_rd) begin
			ind_rdata <= self_point ? PCSIA_ZERO_BYTE : mem_rdata;
		end
	end
endmodule : pcsia_core
`default_nettype wire

// >>> logic/pcsia_pkg.sv
/*
 * Package for the program-flow and indirect addressing block.
 * Assumes a core where the decoder issues one-cycle strobes per instruction cycle.
 */
`default_nettype none
package pcsia_pkg;
	localparam int PCSIA_PC_W = 13;
	localparam int PCSIA_STK_DEPTH = 8;
	localparam int PCSIA_ADDR_W = 9;
	localparam logic [12:0] PCSIA_PC_RST = 13'h0000;
	localparam logic [4:0] PCSIA_LATCH_RST = 5'h00;
	localparam logic [7:0] PCSIA_FSR_RST = 8'h00;
	localparam logic [7:0] PCSIA_INDIRECT_ACCESS_PORT_ADDR = 8'h00;
	localparam logic [7:0] PCSIA_ZERO_BYTE = 8'h00;
	localparam int PCSIA_JMP_LATCH_LSB = 3;
	localparam int PCSIA_JMP_ADDR_W = 11;
	// Flow commands from the decoder
	typedef enum logic [5:0] {
		PCSIA_CMD_NONE = 6'h01,
		PCSIA_CMD_INC = 6'h02,
		PCSIA_CMD_JUMP = 6'h04,
		PCSIA_CMD_CALL = 6'h08,
		PCSIA_CMD_RET = 6'h10,
		PCSIA_CMD_VECT = 6'h20
	} pcsia_cmd_t;
endpackage : pcsia_pkg
`default_nettype wire

// >>> dv/pcsia_dmem.sv
/* Data memory model behind the indirect port.
 Assumes one write strobe per clk_sys edge. */
`default_nettype none
module pcsia_dmem (
	input wire logic clk_sys, // Clock
	input wire logic [8:0] mem_addr, // Address
	input wire logic mem_wr, // Write
	input wire logic [7:0] mem_wdata, // Data in
	output logic [7:0] mem_rdata // Data out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [512];
	// Store strobed writes
	always @(posedge clk_sys) if (mem_wr) mem[mem_addr] <= mem_wdata;
	assign mem_rdata = mem[mem_addr];
endmodule : pcsia_dmem
`default_nettype wire

// >>> dv/pcsia_core_sva.sv
/* Port checker for the flow and indirect block.
 Assumes it is bound onto pcsia_core. */
`default_nettype none
module pcsia_core_sva
	import pcsia_pkg::*;
#(parameter logic [12:0] VECTOR_ADDR = 13'h0004) (
	input wire logic clk_sys, // In
	input wire logic rst_b, // In
	input wire logic clk_en, // In
	input wire logic [5:0] flow_cmd, // In
	input wire logic [10:0] imm_addr, // In
	input wire logic pcl_wr, // In
	input wire logic [7:0] pcl_wdata, // In
	input wire logic bank_select_bit, // In
	input wire logic ind_rd, // In
	input wire logic ind_wr, // In
	input wire logic [7:0] file_pointer_reg, // In
	input wire logic [12:0] pc, // In
	input wire logic [8:0] mem_addr, // In
	input wire logic mem_wr, // In
	input wire logic [7:0] ind_rdata // In
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire go = clk_en & ~pcl_wr;
	wire iw = clk_en & ind_wr;
	// Counter moves
	a_goto_low: assert property (go && flow_cmd == PCSIA_CMD_JUMP |=> pc[10:0] == $past(imm_addr)) else $error("goto");
	a_pcl_load: assert property (clk_en && pcl_wr |=> pc[7:0] == $past(pcl_wdata)) else $error("pcl");
	a_inc_step: assert property (go && flow_cmd == PCSIA_CMD_INC |=> pc == $past(pc) + 13'h1) else $error("inc");
	a_vec_jump: assert property (go && flow_cmd == PCSIA_CMD_VECT |=> pc == VECTOR_ADDR) else $error("vec");
	a_idle_hold: assert property (go && flow_cmd == PCSIA_CMD_NONE |=> $stable(pc)) else $error("idle");
	// Indirect port
	a_self_rd: assert property (clk_en && ind_rd && file_pointer_reg == 8'h00 |=> ind_rdata == 8'h00) else $error("rd");
	a_self_wr: assert property (iw && file_pointer_reg == 8'h00 |=> !mem_wr) else $error("wr0");
	a_ind_addr: assert property (iw && file_pointer_reg != 8'h00 |=> mem_wr &&
		mem_addr == {$past(bank_select_bit), $past(file_pointer_reg)}) else $error("addr");
	c_call: cover property (go && flow_cmd == PCSIA_CMD_CALL);
	c_ret: cover property (go && flow_cmd == PCSIA_CMD_RET);
	c_wr: cover property (iw);
endmodule : pcsia_core_sva
`default_nettype wire

// >>> dv/pcsia_core_tb.sv
/* Self-checking bench for pcsia_core.
 Assumes the data memory model beside it. */
`default_nettype none
module pcsia_core_tb
	import pcsia_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rst_b = 0, clk_en = 1, latch_wr = 0, pcl_wr = 0, fsr_wr = 0;
	logic bank_select_bit = 0, ind_rd = 0, ind_wr = 0, mem_wr;
	logic [5:0] flow_cmd = 6'h01;
	logic [10:0] imm_addr = 11'h000;
	logic [7:0] latch_wdata = 0, pcl_wdata = 0, fsr_wdata = 0, ind_wdata = 0;
	logic [7:0] mem_rdata, file_pointer_reg, mem_wdata, ind_rdata, pc_low_byte_reg;
	logic [12:0] pc;
	logic [8:0] mem_addr;
	int fail_count = 0, checks = 0;
	always #25 clk_sys = ~clk_sys;
	pcsia_core pcsia_core_inst (.*);
	pcsia_dmem pcsia_dmem_inst (.*);
	task automatic step();
		@(posedge clk_sys);
		#5;
	endtask : step
	task automatic cmp(logic [12:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic go(logic [5:0] c, logic [10:0] a);
		flow_cmd = c;
		imm_addr = a;
		step();
		flow_cmd = PCSIA_CMD_NONE;
		step();
	endtask : go
	task automatic set_pc(logic [7:0] hi, lo);
		latch_wdata = hi;
		latch_wr = 1;
		step();
		latch_wr = 0;
		pcl_wdata = lo;
		pcl_wr = 1;
		step();
		pcl_wr = 0;
	endtask : set_pc
	task automatic t_jumps();
		set_pc(8'h1f, 8'h34);
		cmp(pc, 13'h1f34);
		go(PCSIA_CMD_JUMP, 11'h7ff);
		cmp(pc, 13'h1fff);
		set_pc(8'h0a, 8'h00);
		go(PCSIA_CMD_JUMP, 11'h123);
		cmp(pc, 13'h0923);
		go(PCSIA_CMD_INC, 0);
		cmp(pc, 13'h0924);
		cmp(pc_low_byte_reg, 13'h24);
		set_pc(8'h02, 8'hff);
		set_pc(8'h03, 8'h00);
		cmp(pc, 13'h0300);
	endtask : t_jumps
	task automatic t_stack();
		set_pc(8'h18, 8'h00);
		for (int i = 1; i <= 9; i++) go(PCSIA_CMD_CALL, 11'(i * 16));
		for (int k = 8; k >= 1; k--) begin
			go(PCSIA_CMD_RET, 0);
			cmp(pc, 13'h1801 + 13'(k * 16));
		end
		go(PCSIA_CMD_RET, 0);
		cmp(pc, 13'h1881);
		set_pc(8'h18, 8'h55);
		go(PCSIA_CMD_VECT, 0);
		cmp(pc, 13'h0004);
		go(PCSIA_CMD_RET, 0);
		cmp(pc, 13'h1856);
		pcl_wdata = 8'h22;
		pcl_wr = 1;
		step();
		pcl_wr = 0;
		cmp(pc, 13'h1822);
	endtask : t_stack
	task automatic t_indirect();
		fsr_wdata = 8'h40;
		fsr_wr = 1;
		bank_select_bit = 1;
		step();
		fsr_wr = 0;
		cmp(file_pointer_reg, 13'h40);
		ind_wdata = 8'h5a;
		ind_wr = 1;
		step();
		ind_wr = 0;
		step();
		ind_rd = 1;
		step();
		ind_rd = 0;
		step();
		cmp(ind_rdata, 13'h5a);
		fsr_wdata = 8'h00;
		fsr_wr = 1;
		step();
		fsr_wr = 0;
		ind_rd = 1;
		ind_wr = 1;
		step();
		ind_rd = 0;
		ind_wr = 0;
		step();
		cmp(pcsia_dmem_inst.mem[9'h140], 13'h5a);
		cmp(ind_rdata, 13'h0);
	endtask : t_indirect
	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		cmp(pc, 13'h0);
		#5 rst_b = 1;
		repeat (2) step();
		t_jumps();
		t_stack();
		t_indirect();
		rst_b = 0;
		#1 cmp(pc, 13'h0);
		tally_and_finish();
	end
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		tally_and_finish();
	end
endmodule : pcsia_core_tb
bind pcsia_core pcsia_core_sva #(.VECTOR_ADDR(VECTOR_ADDR)) pcsia_core_sva_inst (.*);
`default_nettype wire
